// ==== fir_map.vh ====
`ifndef FIR_MAP_VH
`define FIR_MAP_VH

// register port addresses
`define FIR_ADDR_W              4
`define FIR_ADDR_FAULT_FLAGS    4'h0
`define FIR_ADDR_HALT_FLAGS     4'h1
`define FIR_ADDR_ENABLE_MASK    4'h2
`define FIR_ADDR_PIN_SETUP      4'h3
`define FIR_ADDR_TIMING_SETUP   4'h4

// reset values
`define FIR_RST_ENABLE_MASK     8'h00
`define FIR_RST_PIN_SETUP       8'h42
`define FIR_RST_TIMING_SETUP    8'h00

// fault_event_flags bit positions
`define FIR_BIT_OVERCURRENT     7
`define FIR_BIT_OVERVOLTAGE     6
`define FIR_BIT_CLOCK_ERROR_A   5
`define FIR_BIT_OVERTEMP        4
`define FIR_BIT_BROWNOUT        3
`define FIR_BIT_CLOCK_ERROR_B   2
// clock_halt_event_flags bit positions
`define FIR_BIT_WORD_HALT       7
`define FIR_BIT_MOD_HALT        6
// event_enable_mask positions of the two halt events
`define FIR_EN_WORD_HALT        1
`define FIR_EN_MOD_HALT         0

// notify_pin_setup fields
`define FIR_DRIVE_MSB           7
`define FIR_DRIVE_LSB           5
`define FIR_LEVEL_BIT           4
`define FIR_FUNC_MSB            2
`define FIR_FUNC_LSB            0
`define FIR_DRIVE_PUSH_PULL     3'h1
`define FIR_DRIVE_LOW_ONLY      3'h2
`define FIR_DRIVE_LOW_PULLUP    3'h3
`define FIR_DRIVE_HIGH_PULLDOWN 3'h4
`define FIR_FUNC_DISABLED       3'h1
`define FIR_FUNC_INTERRUPT      3'h2
`define FIR_FUNC_GPO            3'h4
`define FIR_FUNC_PDM_CLOCK      3'h5

// indicator_timing_setup fields
`define FIR_IND_MSB             7
`define FIR_IND_LSB             6
`define FIR_IND_SINGLE          2'h0
`define FIR_IND_REPEAT          2'h1
`define FIR_IND_LEVEL           2'h2

// timing
`define FIR_CLOCK_PERIOD_NS     10
`define FIR_PULSE_WIDTH_NS      2000000
`define FIR_PULSE_PERIOD_NS     4000000

`endif

// ==== fir_pulse_timer.v ====
`timescale 1ns/1ps
`default_nettype none

// pulse generator for the notify indication, counted in clock cycles
module fir_pulse_timer #(
  parameter integer CNT_W         = 24,
  parameter integer WIDTH_CYCLES  = 200000,
  parameter integer PERIOD_CYCLES = 400000
) (
  input  wire             i_clock,
  input  wire             i_rst_n,
  input  wire             i_start,
  input  wire             i_repeat,
  input  wire             i_abort,
  output reg              o_high
);

  // full-width limits first, then cut to the counter on purpose
  localparam [31:0]      WIDTH_LAST_W  = WIDTH_CYCLES - 1;
  localparam [31:0]      PERIOD_LAST_W = PERIOD_CYCLES - 1;
  localparam [CNT_W-1:0] WIDTH_LAST    = WIDTH_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] PERIOD_LAST   = PERIOD_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE       = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] count;
  reg             running;
  reg [CNT_W-1:0] next_count;
  reg             next_running;

  always @* begin
    next_count   = count;
    next_running = running;
    if (i_start) begin
      next_count   = {CNT_W{1'b0}};
      next_running = 1'b1;
    end else if (running) begin
      if (i_abort) begin
        next_running = 1'b0;
      end else if (!i_repeat && count == WIDTH_LAST) begin
        next_running = 1'b0;
      end else if (count == PERIOD_LAST) begin
        next_count   = {CNT_W{1'b0}};
      end else begin
        next_count   = count + CNT_ONE;
      end
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count   <= {CNT_W{1'b0}};
      running <= 1'b0;
      o_high  <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
      o_high  <= next_running && (next_count <= WIDTH_LAST);
    end
  end

endmodule

`default_nettype wire

// ==== fir_flag_router.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fir_map.vh"

module fir_flag_router #(
  parameter integer CNT_W         = 24,
  parameter integer WIDTH_CYCLES  = `FIR_PULSE_WIDTH_NS / `FIR_CLOCK_PERIOD_NS,
  parameter integer PERIOD_CYCLES = `FIR_PULSE_PERIOD_NS / `FIR_CLOCK_PERIOD_NS
) (
  input  wire                   i_clock,
  input  wire                   i_arst_n,
  // event strobes from the protection and clock monitors
  input  wire                   i_overcurrent_evt,
  input  wire                   i_overvoltage_evt,
  input  wire                   i_clock_error_a_evt,
  input  wire                   i_overtemp_evt,
  input  wire                   i_brownout_evt,
  input  wire                   i_clock_error_b_evt,
  input  wire                   i_word_clock_halt_evt,
  input  wire                   i_modulator_clock_halt_evt,
  // divided pdm clock, from another clock
  input  wire                   i_divided_pdm_clock,
  // register port
  input  wire [`FIR_ADDR_W-1:0] i_reg_addr,
  input  wire                   i_reg_wr,
  input  wire                   i_reg_rd,
  input  wire [7:0]             i_reg_wdata,
  output reg  [7:0]             o_reg_rdata,
  output reg                    o_reg_rvalid,
  // notify pin
  output reg                    o_notify_pin_out,
  output reg                    o_notify_pin_oe,
  output reg                    o_notify_pin_pullup,
  output reg                    o_notify_pin_pulldown,
  output reg                    o_notify_pin_buffer_en
);

  // reset release
  reg rst_meta_n;
  reg rst_n;

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // registers
  reg [7:0] fault_event_flags;
  reg [7:0] clock_halt_event_flags;
  reg [7:0] event_enable_mask;
  reg [7:0] notify_pin_setup;
  reg [7:0] indicator_timing_setup;

  reg [7:0] next_fault_event_flags;
  reg [7:0] next_clock_halt_event_flags;

  wire sel_fault  = (i_reg_addr == `FIR_ADDR_FAULT_FLAGS);
  wire sel_halt   = (i_reg_addr == `FIR_ADDR_HALT_FLAGS);
  wire sel_mask   = (i_reg_addr == `FIR_ADDR_ENABLE_MASK);
  wire sel_pin    = (i_reg_addr == `FIR_ADDR_PIN_SETUP);
  wire sel_timing = (i_reg_addr == `FIR_ADDR_TIMING_SETUP);

  wire rd_fault = i_reg_rd && sel_fault;
  wire rd_halt  = i_reg_rd && sel_halt;

  // sticky flags: a new event in the read cycle survives the clear
  always @* begin
    next_fault_event_flags = rd_fault ? 8'h00 : fault_event_flags;
    next_clock_halt_event_flags = rd_halt ? 8'h00 : clock_halt_event_flags;
    if (i_overcurrent_evt) begin
      next_fault_event_flags[`FIR_BIT_OVERCURRENT] = 1'b1;
    end
    if (i_overvoltage_evt) begin
      next_fault_event_flags[`FIR_BIT_OVERVOLTAGE] = 1'b1;
    end
    if (i_clock_error_a_evt) begin
      next_fault_event_flags[`FIR_BIT_CLOCK_ERROR_A] = 1'b1;
    end
    if (i_overtemp_evt) begin
      next_fault_event_flags[`FIR_BIT_OVERTEMP] = 1'b1;
    end
    if (i_brownout_evt) begin
      next_fault_event_flags[`FIR_BIT_BROWNOUT] = 1'b1;
    end
    if (i_clock_error_b_evt) begin
      next_fault_event_flags[`FIR_BIT_CLOCK_ERROR_B] = 1'b1;
    end
    if (i_word_clock_halt_evt) begin
      next_clock_halt_event_flags[`FIR_BIT_WORD_HALT] = 1'b1;
    end
    if (i_modulator_clock_halt_evt) begin
      next_clock_halt_event_flags[`FIR_BIT_MOD_HALT] = 1'b1;
    end
  end

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_event_flags      <= 8'h00;
      clock_halt_event_flags <= 8'h00;
    end else begin
      fault_event_flags      <= next_fault_event_flags;
      clock_halt_event_flags <= next_clock_halt_event_flags;
    end
  end

  // writable setup registers
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      event_enable_mask      <= `FIR_RST_ENABLE_MASK;
      notify_pin_setup       <= `FIR_RST_PIN_SETUP;
      indicator_timing_setup <= `FIR_RST_TIMING_SETUP;
    end else if (i_reg_wr) begin
      if (sel_mask) begin
        event_enable_mask <= i_reg_wdata;
      end
      if (sel_pin) begin
        notify_pin_setup <= i_reg_wdata;
      end
      if (sel_timing) begin
        indicator_timing_setup <= i_reg_wdata;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (1'b1)
          sel_fault:  o_reg_rdata <= fault_event_flags;
          sel_halt:   o_reg_rdata <= clock_halt_event_flags;
          sel_mask:   o_reg_rdata <= event_enable_mask;
          sel_pin:    o_reg_rdata <= notify_pin_setup;
          sel_timing: o_reg_rdata <= indicator_timing_setup;
          default:    o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // flags lined up in mask order
  wire [7:0] flag_vector = {fault_event_flags[`FIR_BIT_OVERCURRENT:`FIR_BIT_CLOCK_ERROR_B],
                            clock_halt_event_flags[`FIR_BIT_WORD_HALT],
                            clock_halt_event_flags[`FIR_BIT_MOD_HALT]};
  wire [7:0] masked_flags = flag_vector & event_enable_mask;
  wire       pending      = |masked_flags;

  // a bit that newly becomes both set and enabled starts an indication,
  // so a late enable of an old flag also counts
  reg  [7:0] masked_prev;
  wire       new_event = |(masked_flags & ~masked_prev);

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      masked_prev <= 8'h00;
    end else begin
      masked_prev <= masked_flags;
    end
  end

  wire [1:0] timing_mode = indicator_timing_setup[`FIR_IND_MSB:`FIR_IND_LSB];
  wire       mode_repeat = (timing_mode == `FIR_IND_REPEAT);
  wire       mode_level  = (timing_mode == `FIR_IND_LEVEL);
  wire       pulse_high;

  // repeats stop as soon as reads leave nothing enabled pending
  fir_pulse_timer #(
    .CNT_W         (CNT_W),
    .WIDTH_CYCLES  (WIDTH_CYCLES),
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_pulse_timer (
    .i_clock  (i_clock),
    .i_rst_n  (rst_n),
    .i_start  (new_event),
    .i_repeat (mode_repeat && pending),
    .i_abort  (mode_repeat && !pending),
    .o_high   (pulse_high)
  );

  // indication level for the chosen timing mode; reserved code stays low
  reg indication;

  always @* begin
    case (timing_mode)
      `FIR_IND_SINGLE: indication = pulse_high;
      `FIR_IND_REPEAT: indication = pulse_high;
      `FIR_IND_LEVEL:  indication = pending;
      default:         indication = 1'b0;
    endcase
  end

  // divided pdm clock: three stages, change taken when the last two agree
  reg pdm_meta;
  reg pdm_s2;
  reg pdm_s3;
  reg pdm_clean;

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pdm_meta  <= 1'b0;
      pdm_s2    <= 1'b0;
      pdm_s3    <= 1'b0;
      pdm_clean <= 1'b0;
    end else begin
      pdm_meta <= i_divided_pdm_clock;
      pdm_s2   <= pdm_meta;
      pdm_s3   <= pdm_s2;
      if (pdm_s2 == pdm_s3) begin
        pdm_clean <= pdm_s3;
      end
    end
  end

  // pin function and drive style
  wire [2:0] pin_function = notify_pin_setup[`FIR_FUNC_MSB:`FIR_FUNC_LSB];
  wire [2:0] pin_drive    = notify_pin_setup[`FIR_DRIVE_MSB:`FIR_DRIVE_LSB];
  wire       pin_level_bit = notify_pin_setup[`FIR_LEVEL_BIT];

  reg pin_level;
  reg pin_active;

  // reserved function codes are treated like the disabled pin
  always @* begin
    pin_level  = 1'b0;
    pin_active = 1'b1;
    case (pin_function)
      `FIR_FUNC_INTERRUPT: pin_level = indication;
      `FIR_FUNC_GPO:       pin_level = pin_level_bit;
      `FIR_FUNC_PDM_CLOCK: pin_level = pdm_clean;
      `FIR_FUNC_DISABLED:  pin_active = 1'b0;
      default:             pin_active = 1'b0;
    endcase
  end

  reg next_out;
  reg next_oe;
  reg next_pullup;
  reg next_pulldown;

  // reserved drive codes fall back to the default open-drain style
  always @* begin
    next_out      = 1'b0;
    next_oe       = 1'b0;
    next_pullup   = 1'b0;
    next_pulldown = 1'b0;
    if (pin_active) begin
      case (pin_drive)
        `FIR_DRIVE_PUSH_PULL: begin
          next_out = pin_level;
          next_oe  = 1'b1;
        end
        `FIR_DRIVE_LOW_ONLY: begin
          next_oe = !pin_level;
        end
        `FIR_DRIVE_LOW_PULLUP: begin
          next_oe     = !pin_level;
          next_pullup = 1'b1;
        end
        `FIR_DRIVE_HIGH_PULLDOWN: begin
          next_out      = 1'b1;
          next_oe       = pin_level;
          next_pulldown = 1'b1;
        end
        default: begin
          next_oe = !pin_level;
        end
      endcase
    end
  end

  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_notify_pin_out       <= 1'b0;
      o_notify_pin_oe        <= 1'b0;
      o_notify_pin_pullup    <= 1'b0;
      o_notify_pin_pulldown  <= 1'b0;
      o_notify_pin_buffer_en <= 1'b0;
    end else begin
      o_notify_pin_out       <= next_out;
      o_notify_pin_oe        <= next_oe;
      o_notify_pin_pullup    <= next_pullup;
      o_notify_pin_pulldown  <= next_pulldown;
      o_notify_pin_buffer_en <= pin_active;
    end
  end

endmodule

`default_nettype wire

// ==== fir_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// host side of the notify pin: resolves the wire level it would see
module fir_host_model (
  input  wire i_clock,
  input  wire i_out,
  input  wire i_oe,
  input  wire i_pullup,
  input  wire i_pulldown,
  output wire o_level
);
  reg  last;
  wire held = i_oe || i_pullup || i_pulldown;
  initial last = 1'b0;
  // an undriven, unpulled line shows the inverse of its last level, never a stale copy
  always @(posedge i_clock) begin
    if (held) begin
      last <= o_level;
    end
  end
  assign o_level = i_oe ? i_out : i_pullup ? 1'b1 : i_pulldown ? 1'b0 : ~last;
endmodule

`default_nettype wire

// ==== fir_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fir_map.vh"

module fir_checker #(
  parameter integer CNT_W         = 24,
  parameter integer WIDTH_CYCLES  = 8,
  parameter integer PERIOD_CYCLES = 16
) (
  input  wire                   i_clock,
  input  wire                   i_arst_n,
  input  wire                   i_brownout_evt,
  input  wire [`FIR_ADDR_W-1:0] i_reg_addr,
  input  wire                   i_reg_wr,
  input  wire                   i_reg_rd,
  input  wire [7:0]             i_reg_wdata,
  input  wire [7:0]             o_reg_rdata,
  input  wire                   o_reg_rvalid,
  input  wire                   o_notify_pin_out,
  input  wire                   o_notify_pin_oe,
  input  wire                   o_notify_pin_pullup,
  input  wire                   o_notify_pin_pulldown,
  input  wire                   o_notify_pin_buffer_en
);
  reg [1:0] rst_cnt;
  reg [7:0] pin;
  reg [7:0] prev_pin;
  reg [7:0] mask;
  reg [7:0] tim;
  reg [7:0] hi_cnt;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_cnt <= 2'h0;
      pin <= 8'h42;
      prev_pin <= 8'h42;
      mask <= 8'h00;
      tim <= 8'h00;
      hi_cnt <= 8'h00;
    end else begin
      if (rst_cnt != 2'h3)
        rst_cnt <= rst_cnt + 2'h1;
      if (i_reg_wr && i_reg_addr == `FIR_ADDR_PIN_SETUP)
        pin <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `FIR_ADDR_ENABLE_MASK)
        mask <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `FIR_ADDR_TIMING_SETUP)
        tim <= i_reg_wdata;
      prev_pin <= pin;
      hi_cnt <= o_notify_pin_out ? hi_cnt + 8'h1 : 8'h00;
    end
  end
  // pin outputs lag the setup register by one cycle, so judge only settled setups
  wire       cfg = rst_cnt == 2'h3 && pin == prev_pin;
  wire [2:0] drv = pin[7:5];
  wire [2:0] fn  = pin[2:0];
  wire       on  = cfg && (fn == `FIR_FUNC_GPO || fn == `FIR_FUNC_INTERRUPT);
  wire       irq = cfg && fn == `FIR_FUNC_INTERRUPT && drv == `FIR_DRIVE_PUSH_PULL;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  a_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 4'h4 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pin_off: assert property (cfg && fn == `FIR_FUNC_DISABLED |->
    !o_notify_pin_buffer_en && !o_notify_pin_oe) else $error("disabled pin active");
  a_gpo_level: assert property (cfg && fn == `FIR_FUNC_GPO && drv == 3'h1 |->
    o_notify_pin_out == pin[4] && o_notify_pin_oe) else $error("gpo level wrong");
  a_low_only: assert property (on && drv == 3'h2 |->
    !o_notify_pin_out && !o_notify_pin_pullup) else $error("open drain drives high");
  a_pullup_drive: assert property (on && drv == 3'h3 |->
    o_notify_pin_pullup && !o_notify_pin_out) else $error("pull-up code wrong");
  a_pulldown_drive: assert property (on && drv == 3'h4 |->
    o_notify_pin_pulldown && o_notify_pin_out) else $error("pull-down code wrong");
  a_pulse_width: assert property (irq && tim[7:6] == 2'h0 && $fell(o_notify_pin_out) |->
    hi_cnt == WIDTH_CYCLES) else $error("single pulse width wrong");
  a_event_rise: assert property (irq && tim[7:6] == 2'h2 && mask[3] && i_brownout_evt |->
    ##2 o_notify_pin_out) else $error("enabled event not indicated");
  a_masked_quiet: assert property (irq && tim[7:6] == 2'h2 && tim == $past(tim, 2) &&
    mask == 8'h00 && $past(mask) == 8'h00 && $past(mask, 2) == 8'h00 |-> !o_notify_pin_out)
    else $error("masked event drives pin");

  c_single: cover property (irq && tim[7:6] == 2'h0 && $fell(o_notify_pin_out));
  c_repeat: cover property (irq && tim[7:6] == 2'h1 && $rose(o_notify_pin_out));
  c_gpo: cover property (cfg && fn == `FIR_FUNC_GPO && o_notify_pin_out);
endmodule

bind fir_flag_router fir_checker #(
  .CNT_W(CNT_W), .WIDTH_CYCLES(WIDTH_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)
) i_chk (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_brownout_evt(i_brownout_evt),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_notify_pin_out(o_notify_pin_out), .o_notify_pin_oe(o_notify_pin_oe),
  .o_notify_pin_pullup(o_notify_pin_pullup), .o_notify_pin_pulldown(o_notify_pin_pulldown),
  .o_notify_pin_buffer_en(o_notify_pin_buffer_en)
);

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fir_map.vh"

module tb_top;
  localparam integer W = 8;
  localparam integer P = 16;
  reg        clk;
  reg        arst_n;
  reg        rd;
  reg        wr;
  reg        pdm;
  reg  [7:0] ev;
  reg  [7:0] wdata;
  reg  [3:0] addr;
  wire [7:0] rdata;
  wire       rvalid, p_out, p_oe, p_pu, p_pd, p_buf, lvl;
  integer    error_cnt, n_compared, n, i;

  fir_flag_router #(.WIDTH_CYCLES(W), .PERIOD_CYCLES(P)) i_dut (
    .i_clock(clk), .i_arst_n(arst_n), .i_overcurrent_evt(ev[7]), .i_overvoltage_evt(ev[6]),
    .i_clock_error_a_evt(ev[5]), .i_overtemp_evt(ev[4]), .i_brownout_evt(ev[3]),
    .i_clock_error_b_evt(ev[2]), .i_word_clock_halt_evt(ev[1]),
    .i_modulator_clock_halt_evt(ev[0]), .i_divided_pdm_clock(pdm), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_notify_pin_out(p_out), .o_notify_pin_oe(p_oe),
    .o_notify_pin_pullup(p_pu), .o_notify_pin_pulldown(p_pd), .o_notify_pin_buffer_en(p_buf));
  fir_host_model i_host (.i_clock(clk), .i_out(p_out), .i_oe(p_oe), .i_pullup(p_pu),
    .i_pulldown(p_pd), .o_level(lvl));

  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task reg_wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge clk); addr = a; wdata = d; wr = 1'b1;
      @(negedge clk); wr = 1'b0;
    end
  endtask
  task reg_rd(input [3:0] a, input [7:0] exp);
    begin
      @(negedge clk); addr = a; rd = 1'b1;
      @(negedge clk); rd = 1'b0;
      chk({7'h0, rvalid}, 8'h01);
      chk(rdata, exp);
    end
  endtask
  task fire(input [7:0] e);
    begin
      @(negedge clk); ev = e;
      @(negedge clk); ev = 8'h00;
    end
  endtask
  task wait_lvl(input integer cycles, input v);
    begin
      repeat (cycles) @(negedge clk);
      chk({7'h0, lvl}, {7'h0, v});
    end
  endtask
  // waits, bounded, for level v, then counts how long it lasts
  task run_len(input v, output integer len);
    begin
      n = 0;
      while (lvl !== v && n < 40) begin @(negedge clk); n = n + 1; end
      len = 0;
      while (lvl === v && len < 200) begin @(negedge clk); len = len + 1; end
    end
  endtask
  function [3:0] drv_exp(input [2:0] d, input lv);
    case (d)
      3'h1: drv_exp = {1'b1, lv, 2'b00};
      3'h3: drv_exp = {~lv, 3'b010};
      3'h4: drv_exp = {lv, 3'b101};
      default: drv_exp = {~lv, 3'b000};
    endcase
  endfunction

  task t_reset;
    begin
      reg_rd(`FIR_ADDR_ENABLE_MASK, 8'h00);
      reg_rd(`FIR_ADDR_PIN_SETUP, 8'h42);
      reg_rd(`FIR_ADDR_TIMING_SETUP, 8'h00);
      reg_rd(4'h9, 8'h00);
      chk({5'h0, p_oe, p_out, p_buf}, 8'h05);
      $display("t_reset done");
    end
  endtask
  task t_flags;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        fire(8'h01 << i);
        reg_rd(`FIR_ADDR_FAULT_FLAGS, (i > 1) ? (8'h01 << i) : 8'h00);
        reg_rd(`FIR_ADDR_HALT_FLAGS, (i == 1) ? 8'h80 : (i == 0) ? 8'h40 : 8'h00);
      end
      fire(8'hff);
      reg_wr(`FIR_ADDR_FAULT_FLAGS, 8'h00);
      wait_lvl(3, 1'b0);
      reg_rd(`FIR_ADDR_FAULT_FLAGS, 8'hfc);
      reg_rd(`FIR_ADDR_FAULT_FLAGS, 8'h00);
      reg_rd(`FIR_ADDR_HALT_FLAGS, 8'hc0);
      reg_rd(`FIR_ADDR_HALT_FLAGS, 8'h00);
      $display("t_flags done");
    end
  endtask
  task t_pulse;
    begin
      reg_wr(`FIR_ADDR_PIN_SETUP, 8'h22);
      reg_wr(`FIR_ADDR_ENABLE_MASK, 8'h88);
      fire(8'h08);
      run_len(1'b1, n); chk(n[7:0], W[7:0]);
      fire(8'h40);
      wait_lvl(3 * W, 1'b0);
      reg_wr(`FIR_ADDR_ENABLE_MASK, 8'hc8);
      run_len(1'b1, n); chk(n[7:0], W[7:0]);
      reg_rd(`FIR_ADDR_FAULT_FLAGS, 8'h48);
      $display("t_pulse done");
    end
  endtask
  task t_repeat;
    begin
      reg_wr(`FIR_ADDR_TIMING_SETUP, 8'h40);
      fire(8'h80);
      run_len(1'b1, n); chk(n[7:0], W[7:0]);
      run_len(1'b0, n); chk(n[7:0], P[7:0] - W[7:0]);
      run_len(1'b1, n); chk(n[7:0], W[7:0]);
      reg_rd(`FIR_ADDR_FAULT_FLAGS, 8'h80);
      reg_rd(`FIR_ADDR_HALT_FLAGS, 8'h00);
      n = 0;
      repeat (2 * P) begin @(negedge clk); n = n + lvl; end
      chk(n[7:0], 8'h00);
      $display("t_repeat done");
    end
  endtask
  task t_level;
    begin
      reg_wr(`FIR_ADDR_TIMING_SETUP, 8'h80);
      reg_wr(`FIR_ADDR_ENABLE_MASK, 8'h00);
      fire(8'h12);
      wait_lvl(4, 1'b0);
      reg_wr(`FIR_ADDR_ENABLE_MASK, 8'h12);
      wait_lvl(3 * P, 1'b1);
      reg_rd(`FIR_ADDR_FAULT_FLAGS, 8'h10);
      wait_lvl(4, 1'b1);
      reg_rd(`FIR_ADDR_HALT_FLAGS, 8'h80);
      wait_lvl(4, 1'b0);
      reg_wr(`FIR_ADDR_ENABLE_MASK, 8'h08);
      fire(8'h08);
      wait_lvl(1, 1'b1);
      reg_wr(`FIR_ADDR_TIMING_SETUP, 8'hc0);
      wait_lvl(3, 1'b0);
      reg_rd(`FIR_ADDR_FAULT_FLAGS, 8'h08);
      $display("t_level done");
    end
  endtask
  task t_drive;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        reg_wr(`FIR_ADDR_PIN_SETUP, {i[3:1] + 3'h1, i[0], 4'h4});
        wait_lvl(2, i[0]);
        chk({4'h0, p_oe, p_out, p_pu, p_pd}, {4'h0, drv_exp(i[3:1] + 3'h1, i[0])});
      end
      $display("t_drive done");
    end
  endtask
  task t_func;
    begin
      reg_wr(`FIR_ADDR_PIN_SETUP, 8'h21);
      wait_lvl(2, 1'b1);
      chk({6'h0, p_buf, p_oe}, 8'h00);
      reg_wr(`FIR_ADDR_PIN_SETUP, 8'h25);
      pdm = 1'b1;
      wait_lvl(10, 1'b1);
      pdm = 1'b0;
      wait_lvl(10, 1'b0);
      reg_wr(`FIR_ADDR_PIN_SETUP, 8'h23);
      wait_lvl(2, 1'b1);
      chk({7'h0, p_buf}, 8'h00);
      reg_wr(`FIR_ADDR_PIN_SETUP, 8'h22);
      wait_lvl(2, 1'b0);
      chk({7'h0, p_buf}, 8'h01);
      $display("t_func done");
    end
  endtask
  task test_done;
    begin
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0; rd = 1'b0; wr = 1'b0; pdm = 1'b0;
    ev = 8'h00; wdata = 8'h00; addr = 4'h0;
    error_cnt = 0; n_compared = 0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset; t_flags; t_pulse; t_repeat; t_level; t_drive; t_func;
    test_done;
  end
  // tests need about 400 cycles
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule

`default_nettype wire
